/* src/chp_hazard_ctrl.sv */
// Purpose: Stall and replay control for first- and mid-level data pipelines
// Assumes: All inputs synchronous to ref_clk_in; upstream holds its mid-level
//          pair while ml_stall_out is high
// Notes:   Prefetch queue is a small circular buffer that drops on overflow
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Same-cycle hitting stores, equal va 7:5, different 11:8: replay second
// - A replayed store or write re-executes five cycles later
// - Bank is address 7:4; two reads or two writes to different addresses never share a bank per cycle
// - Paired reads to one bank, different addresses: stall one cycle
// - Paired writes to one bank, different addresses: stall one cycle
// - Read and write bank conflict together still cost only one stall
// - Queue-issued pairs never conflict on banks; only bypass pairs may
// - Store then read same bank four cycles later, other address: stall
// - Both operations filling first level: one stall, shared with read
// - Queue only tries to avoid fill-port pairs; they still stall
// - First-level write matching a fill on va 13:6 is replayed
// - Prefetches run detached, need an issue port, drop on overflow
// - Translation-miss prefetches with defer hint enter the prefetch queue
// - Store then mid-level fill four cycles later: stall one cycle
module chp_hazard_ctrl
  import chp_pkg::*;
#(
  parameter int unsigned PF_DEPTH = chp_pkg::PF_DEPTH_DEF
) (
  input  wire logic                ref_clk_in,
  input  wire logic                sys_rst_in,
  input  wire chp_pkg::chp_fst_t   fl_st0_in,
  input  wire chp_pkg::chp_fst_t   fl_st1_in,
  input  wire chp_pkg::chp_ffill_t fl_fill_in,
  input  wire chp_pkg::chp_pair_t  ml_pair_in,
  input  wire logic                ml_fill_in,
  input  wire chp_pkg::chp_pf_t    pf_in,
  input  wire logic                pf_port_free_in,
  output logic [1:0]               fl_replay_out,
  output logic                     fl_reexec_out,
  output logic                     ml_stall_out,
  output chp_pkg::chp_pair_t       ml_pair_out,
  output logic                     ml_queue_err_out,
  output chp_pkg::chp_pf_req_t     pf_issue_out,
  output logic                     pf_drop_out
);
  import chp_pkg::*;

  localparam int unsigned PTR_W = (PF_DEPTH > 1) ? $clog2(PF_DEPTH) : 1;

  if (PF_DEPTH < 2 || (PF_DEPTH & (PF_DEPTH - 1)) != 0) begin : g_depth_chk
    $error("PF_DEPTH must be a power of two, at least 2");
  end

  function automatic logic [3:0] bank_of(input logic [ADDR_W-1:0] a);
    return a[BANK_HI:BANK_LO];
  endfunction

  // Same bank but a different full address
  function automatic logic bank_clash(input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] b);
    return (bank_of(a) == bank_of(b)) && (a != b);
  endfunction

  function automatic logic fill_match(input chp_fst_t s,
                                      input chp_ffill_t f);
    return s.valid && f.valid &&
           (s.va[FILL_HI:FILL_LO] == f.va[FILL_HI:FILL_LO]);
  endfunction

  // ---------------- First-level replay ----------------
  logic [1:0] next_fl_replay;
  logic       next_fl_reexec;
  logic [2:0] replay_cnt;
  logic [2:0] next_replay_cnt;
  logic       st_pair_clash;

  always_comb begin
    st_pair_clash = fl_st0_in.valid && fl_st0_in.hit &&
                    fl_st1_in.valid && fl_st1_in.hit &&
                    (fl_st0_in.va[SET_HI:SET_LO] ==
                     fl_st1_in.va[SET_HI:SET_LO]) &&
                    (fl_st0_in.va[WAY_HI:WAY_LO] !=
                     fl_st1_in.va[WAY_HI:WAY_LO]);
    next_fl_replay[0] = fill_match(fl_st0_in, fl_fill_in);
    next_fl_replay[1] = st_pair_clash ||
                        fill_match(fl_st1_in, fl_fill_in);
    next_fl_reexec  = 1'b0;
    next_replay_cnt = replay_cnt;
    if (replay_cnt != 3'h0) begin
      next_replay_cnt = replay_cnt - 3'h1;
      next_fl_reexec  = (replay_cnt == 3'h1);
    end
    // A newer replay restarts the penalty window for the newest write
    if (next_fl_replay != 2'h0) begin
      next_replay_cnt = REPLAY_LOAD;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      fl_replay_out <= 2'h0;
      fl_reexec_out <= 1'b0;
      replay_cnt    <= 3'h0;
    end else begin
      fl_replay_out <= next_fl_replay;
      fl_reexec_out <= next_fl_reexec;
      replay_cnt    <= next_replay_cnt;
    end
  end

  // ---------------- Mid-level pipeline ----------------
  chp_pair_t hold;
  chp_pair_t next_hold;
  chp_pair_t next_ml_pair;
  chp_pair_t cand;
  chp_pair_t hist [RW_DISTANCE];
  chp_pair_t next_hist [RW_DISTANCE];
  logic      next_ml_stall;
  logic      next_queue_err;
  logic      rr_clash;
  logic      ww_clash;
  logic      fp_clash;
  logic      rw_clash;
  logic      fs_clash;
  logic      intra;
  logic      inter;
  logic      old_wr;
  chp_mop_t  rw_w;
  chp_mop_t  rw_r;

  always_comb begin
    rw_w = '0;
    rw_r = '0;
    // While stalled the held pair is replayed, new input is ignored
    cand = ml_stall_out ? hold : ml_pair_in;
    rr_clash = cand.op0.valid && cand.op1.valid && cand.op0.rd &&
               cand.op1.rd && bank_clash(cand.op0.addr,
                                         cand.op1.addr);
    ww_clash = cand.op0.valid && cand.op1.valid && cand.op0.wr &&
               cand.op1.wr && bank_clash(cand.op0.addr,
                                         cand.op1.addr);
    fp_clash = cand.op0.valid && cand.op1.valid &&
               cand.op0.fill && cand.op1.fill;
    // Reads four issue cycles after a write to the same bank
    rw_clash = 1'b0;
    old_wr   = 1'b0;
    for (int i = 0; i < 2; i++) begin
      for (int j = 0; j < 2; j++) begin
        rw_w = (i == 0) ? hist[RW_DISTANCE-1].op0 : hist[RW_DISTANCE-1].op1;
        rw_r = (j == 0) ? cand.op0 : cand.op1;
        if (rw_w.valid && rw_w.wr && rw_r.valid && rw_r.rd &&
            bank_clash(rw_w.addr, rw_r.addr)) begin
          rw_clash = 1'b1;
        end
      end
    end
    old_wr = (hist[RW_DISTANCE-1].op0.valid && hist[RW_DISTANCE-1].op0.wr) ||
             (hist[RW_DISTANCE-1].op1.valid && hist[RW_DISTANCE-1].op1.wr);
    fs_clash = old_wr && ml_fill_in;
    // A split remainder holds one op only, so it can never clash within the pair again;
    // a whole pair held by an inter clash must still be split
    intra = rr_clash || ww_clash || fp_clash;
    inter = rw_clash || fs_clash;
    next_queue_err = !ml_stall_out && (rr_clash || ww_clash) &&
                     !(cand.op0.bypass && cand.op1.bypass);

    next_ml_pair  = '0;
    next_hold     = hold;
    next_ml_stall = 1'b0;
    if (inter) begin
      // Whole pair waits a cycle; the bubble may set up a later clash
      next_hold     = cand;
      next_ml_stall = 1'b1;
    end else if (intra) begin
      // Older op goes first so program order is kept
      next_ml_pair.op0 = cand.op0;
      next_hold        = '0;
      next_hold.op0    = cand.op1;
      next_ml_stall    = 1'b1;
    end else begin
      next_ml_pair = cand;
      next_hold    = '0;
    end

    next_hist[0] = next_ml_pair;
    for (int k = 1; k < RW_DISTANCE; k++) begin
      next_hist[k] = hist[k-1];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      hold             <= '0;
      ml_pair_out      <= '0;
      ml_stall_out     <= 1'b0;
      ml_queue_err_out <= 1'b0;
      for (int k = 0; k < RW_DISTANCE; k++) begin
        hist[k] <= '0;
      end
    end else begin
      hold             <= next_hold;
      ml_pair_out      <= next_ml_pair;
      ml_stall_out     <= next_ml_stall;
      ml_queue_err_out <= next_queue_err;
      for (int k = 0; k < RW_DISTANCE; k++) begin
        hist[k] <= next_hist[k];
      end
    end
  end

  // ---------------- Prefetch queue ----------------
  logic [ADDR_W-1:0] pf_mem [PF_DEPTH];
  logic [PTR_W:0]    pf_wr_ptr;
  logic [PTR_W:0]    pf_rd_ptr;
  logic [PTR_W:0]    next_pf_wr_ptr;
  logic [PTR_W:0]    next_pf_rd_ptr;
  chp_pf_req_t       next_pf_issue;
  logic              next_pf_drop;
  logic              pf_push;
  logic              pf_full;
  logic              pf_empty;
  logic              pf_want;

  always_comb begin
    pf_empty = (pf_wr_ptr == pf_rd_ptr);
    pf_full  = (pf_wr_ptr[PTR_W] != pf_rd_ptr[PTR_W]) &&
               (pf_wr_ptr[PTR_W-1:0] == pf_rd_ptr[PTR_W-1:0]);
    // Long aux-port bursts beyond the queue depth are dropped here
    pf_want = pf_in.valid && (pf_in.aux_port ||
              (pf_in.xlat_miss && pf_in.defer_hint));
    next_pf_issue  = '0;
    next_pf_rd_ptr = pf_rd_ptr;
    if (pf_port_free_in && !pf_empty) begin
      next_pf_issue.valid = 1'b1;
      next_pf_issue.addr  = pf_mem[pf_rd_ptr[PTR_W-1:0]];
      next_pf_rd_ptr      = pf_rd_ptr + 1'b1;
    end
    // Full is judged before this cycle's pop: simpler, at most one early drop
    pf_push        = pf_want && !pf_full;
    next_pf_drop   = pf_want && pf_full;
    next_pf_wr_ptr = pf_push ? pf_wr_ptr + 1'b1 : pf_wr_ptr;
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      pf_wr_ptr    <= '0;
      pf_rd_ptr    <= '0;
      pf_issue_out <= '0;
      pf_drop_out  <= 1'b0;
    end else begin
      pf_wr_ptr    <= next_pf_wr_ptr;
      pf_rd_ptr    <= next_pf_rd_ptr;
      pf_issue_out <= next_pf_issue;
      pf_drop_out  <= next_pf_drop;
    end
  end

  // Storage needs no reset; only pointers define what is valid
  always_ff @(posedge ref_clk_in) begin
    if (pf_push) begin
      pf_mem[pf_wr_ptr[PTR_W-1:0]] <= pf_in.addr;
    end
  end

endmodule // chp_hazard_ctrl

`default_nettype wire

/* src/chp_pkg.sv */
// Purpose: Shared types and constants for the cache pipeline hazard control
// Assumes: One core clock, synchronous active-high reset
// Notes:   Operation descriptors travel as packed structs
package chp_pkg;

  localparam int unsigned VA_W          = 14;
  localparam int unsigned ADDR_W        = 16;
  localparam int unsigned BANK_LO       = 4;
  localparam int unsigned BANK_HI       = 7;
  localparam int unsigned SET_LO        = 5;
  localparam int unsigned SET_HI        = 7;
  localparam int unsigned WAY_LO        = 8;
  localparam int unsigned WAY_HI        = 11;
  localparam int unsigned FILL_LO       = 6;
  localparam int unsigned FILL_HI       = 13;
  localparam int unsigned REPLAY_CYCLES = 5;
  localparam int unsigned RW_DISTANCE   = 4;
  localparam int unsigned PF_DEPTH_DEF  = 8;
  localparam int unsigned PF_BURST_MAX  = 8;
  localparam logic [2:0]  REPLAY_LOAD   = 3'(REPLAY_CYCLES);

  // First-level store presented by the issue pipeline
  typedef struct packed {
    logic            valid;
    logic            hit;
    logic [VA_W-1:0] va;
  } chp_fst_t;

  // First-level fill arriving from the mid-level cache
  typedef struct packed {
    logic            valid;
    logic [VA_W-1:0] va;
  } chp_ffill_t;

  // Mid-level pipeline operation
  typedef struct packed {
    logic              valid;
    logic              rd;
    logic              wr;
    logic              fill;
    logic              bypass;
    logic [ADDR_W-1:0] addr;
  } chp_mop_t;

  // Prefetch request from the issue pipeline
  typedef struct packed {
    logic              valid;
    logic              aux_port;
    logic              xlat_miss;
    logic              defer_hint;
    logic [ADDR_W-1:0] addr;
  } chp_pf_t;

  // Prefetch handed to a memory issue port
  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
  } chp_pf_req_t;

  typedef struct packed {
    chp_mop_t op1;
    chp_mop_t op0;
  } chp_pair_t;

endpackage

/* verif/chp_hazard_asserts.sv */
// Purpose: Concurrent checks on the hazard controller ports
// Assumes: One clock; pipe history is judged at the issued-pair outputs
// Notes:   Bound into every chp_hazard_ctrl instance
`timescale 1ns/100ps
`default_nettype none
module chp_hazard_asserts
  import chp_pkg::*;
(
  input wire logic                 ref_clk_in,
  input wire logic                 sys_rst_in,
  input wire chp_pkg::chp_fst_t    fl_st0_in,
  input wire chp_pkg::chp_fst_t    fl_st1_in,
  input wire chp_pkg::chp_ffill_t  fl_fill_in,
  input wire chp_pkg::chp_pair_t   ml_pair_in,
  input wire logic                 ml_fill_in,
  input wire chp_pkg::chp_pf_t     pf_in,
  input wire logic                 pf_port_free_in,
  input wire logic [1:0]           fl_replay_out,
  input wire logic                 fl_reexec_out,
  input wire logic                 ml_stall_out,
  input wire chp_pkg::chp_pair_t   ml_pair_out,
  input wire logic                 ml_queue_err_out,
  input wire chp_pkg::chp_pf_req_t pf_issue_out,
  input wire logic                 pf_drop_out
);
  logic rrww, intra, stclash, wr_out;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  function automatic logic bk(chp_mop_t a, chp_mop_t b);
    return a.valid && b.valid && a.addr[7:4] == b.addr[7:4] && a.addr != b.addr;
  endfunction
  function automatic logic wrd(chp_mop_t w, chp_mop_t r);
    return bk(w, r) && w.wr && r.rd;
  endfunction
  assign rrww = bk(ml_pair_in.op0, ml_pair_in.op1) &&
    ((ml_pair_in.op0.rd && ml_pair_in.op1.rd) ||
     (ml_pair_in.op0.wr && ml_pair_in.op1.wr));
  assign intra = rrww || (ml_pair_in.op0.valid && ml_pair_in.op1.valid &&
    ml_pair_in.op0.fill && ml_pair_in.op1.fill);
  assign stclash = fl_st0_in.valid && fl_st0_in.hit && fl_st1_in.valid &&
    fl_st1_in.hit && fl_st0_in.va[7:5] == fl_st1_in.va[7:5] &&
    fl_st0_in.va[11:8] != fl_st1_in.va[11:8];
  assign wr_out = (ml_pair_out.op0.valid && ml_pair_out.op0.wr) ||
    (ml_pair_out.op1.valid && ml_pair_out.op1.wr);
  pair_clash_a: assert property (
    stclash |=> fl_replay_out[1]) else $error("store pair not replayed");
  fill_match_a: assert property (
    fl_fill_in.valid && fl_st1_in.valid &&
    fl_st1_in.va[13:6] == fl_fill_in.va[13:6] |=> fl_replay_out[1])
    else $error("write against fill not replayed");
  replay_delay_a: assert property (
    fl_replay_out != 2'h0 ##1 (fl_replay_out == 2'h0) [*4] |=> fl_reexec_out)
    else $error("re-execute not five cycles after replay");
  intra_split_a: assert property (
    !ml_stall_out && intra |=> ml_stall_out &&
    ml_pair_out.op0 == $past(ml_pair_in.op0) ##1
    ml_pair_out.op0 == $past(ml_pair_in.op1, 2))
    else $error("paired clash not split by one stall");
  queue_err_a: assert property (
    !ml_stall_out && rrww && !ml_pair_in.op0.bypass &&
    !ml_pair_in.op1.bypass |=> ml_queue_err_out)
    else $error("queued clash pair not flagged");
  bank_share_a: assert property (
    !(bk(ml_pair_out.op0, ml_pair_out.op1) &&
    ((ml_pair_out.op0.rd && ml_pair_out.op1.rd) ||
     (ml_pair_out.op0.wr && ml_pair_out.op1.wr))))
    else $error("two issued ops share a bank");
  rw_gap_a: assert property (
    !(wrd($past(ml_pair_out.op0, 4), ml_pair_out.op0) ||
      wrd($past(ml_pair_out.op1, 4), ml_pair_out.op0) ||
      wrd($past(ml_pair_out.op0, 4), ml_pair_out.op1) ||
      wrd($past(ml_pair_out.op1, 4), ml_pair_out.op1)))
    else $error("read issued four cycles after write to bank");
  fill_store_a: assert property (
    !ml_stall_out && ml_fill_in && $past(wr_out, 3) |=>
    ml_stall_out && !ml_pair_out.op0.valid)
    else $error("fill after store did not stall");
  pf_drop_a: assert property (
    pf_drop_out |-> $past(pf_in.valid &&
    (pf_in.aux_port || (pf_in.xlat_miss && pf_in.defer_hint))))
    else $error("drop without queued prefetch");
  pf_issue_a: assert property (
    pf_issue_out.valid |-> $past(pf_port_free_in))
    else $error("prefetch issued without free port");
  cover property (fl_reexec_out);
  cover property (ml_stall_out ##1 !ml_stall_out);
  cover property (pf_drop_out);
endmodule // chp_hazard_asserts
bind chp_hazard_ctrl chp_hazard_asserts u_chk (
  .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .fl_st0_in(fl_st0_in),
  .fl_st1_in(fl_st1_in), .fl_fill_in(fl_fill_in), .ml_pair_in(ml_pair_in),
  .ml_fill_in(ml_fill_in), .pf_in(pf_in), .pf_port_free_in(pf_port_free_in),
  .fl_replay_out(fl_replay_out), .fl_reexec_out(fl_reexec_out),
  .ml_stall_out(ml_stall_out), .ml_pair_out(ml_pair_out),
  .ml_queue_err_out(ml_queue_err_out), .pf_issue_out(pf_issue_out),
  .pf_drop_out(pf_drop_out));
`default_nettype wire

/* verif/chp_issue_model.sv */
// Purpose: Issue-side model offering mid-level pairs
// Assumes: Bench supplies the next pair every cycle
// Notes:   Pair is held while the pipe stalls, so the bench leaves gaps
`timescale 1ns/100ps
`default_nettype none
module chp_issue_model
  import chp_pkg::*;
(
  input  wire logic               ref_clk_in,
  input  wire logic               sys_rst_in,
  input  wire logic               ml_stall_in,
  input  wire chp_pkg::chp_pair_t next_pair_in,
  output chp_pkg::chp_pair_t      pair_out
);
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      pair_out <= '0;
    end else if (!ml_stall_in) begin
      pair_out <= next_pair_in;
    end
  end
endmodule // chp_issue_model
`default_nettype wire

/* verif/tb_top.sv */
// Purpose: Self-checking bench for the cache pipeline hazard controller
// Assumes: PF_DEPTH set to 4 so the prefetch queue overflows quickly
// Notes:   Inputs move on the rising edge; outputs read on the falling edge
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import chp_pkg::*;
  logic        ref_clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        mfill = 1'b0, pfree = 1'b0, reexec, stall, qerr, pdrop;
  logic [1:0]  rep, er = 2'h0;
  logic [15:0] rnd = 16'h75b0;
  logic [15:0] q_out[$], q_exp[$];
  logic [23:0] tbl = 24'b100_100_000_011_010_100_100_100;
  chp_fst_t    st0 = '0, st1 = '0, v0, v1;
  chp_ffill_t  ffl = '0, vf;
  chp_pair_t   nxt = '0, pin, pout;
  chp_pf_t     pf = '0;
  chp_pf_req_t pfo;
  int fails = 0, total_checks = 0, cyc = 0, cnt = 0, ed = 0;
  int stalls = 0, drops = 0, errs = 0, n;
  always #12.5 ref_clk_in = ~ref_clk_in;
  chp_issue_model partner (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .ml_stall_in(stall), .next_pair_in(nxt), .pair_out(pin));
  chp_hazard_ctrl #(.PF_DEPTH(4)) uut (.ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in), .fl_st0_in(st0), .fl_st1_in(st1),
    .fl_fill_in(ffl), .ml_pair_in(pin), .ml_fill_in(mfill), .pf_in(pf),
    .pf_port_free_in(pfree), .fl_replay_out(rep), .fl_reexec_out(reexec),
    .ml_stall_out(stall), .ml_pair_out(pout), .ml_queue_err_out(qerr),
    .pf_issue_out(pfo), .pf_drop_out(pdrop));
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic chp_mop_t mk(logic [3:0] k, logic [15:0] a);
    return {1'b1, k, a};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    if (fails == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmpq();
    check(32'(q_out.size()), 32'(q_exp.size()));
    foreach (q_exp[i]) check({16'h0, q_out[i]}, {16'h0, q_exp[i]});
    q_out.delete();
    q_exp.delete();
  endtask
  task automatic mpair(chp_pair_t p, int gap);
    @(posedge ref_clk_in) nxt <= p;
    @(posedge ref_clk_in) nxt <= '0;
    repeat (gap) @(posedge ref_clk_in);
    if (p.op0.valid) q_exp.push_back(p.op0.addr);
    if (p.op1.valid) q_exp.push_back(p.op1.addr);
  endtask
  always @(negedge ref_clk_in) begin
    if (!sys_rst_in) begin
      stalls += stall;
      drops += pdrop;
      errs += qerr;
      if (pout.op0.valid) q_out.push_back(pout.op0.addr);
      if (pout.op1.valid) q_out.push_back(pout.op1.addr);
      if (pfo.valid) q_out.push_back(pfo.addr);
    end
  end
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc > 2000) begin
      fails++;
      test_done();
    end
  end
  initial begin
    repeat (3) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    repeat (300) begin
      @(posedge ref_clk_in);
      rnd = lfsr(rnd);
      v0 = {rnd[5] | rnd[6], rnd[4], rnd[13:0]};
      v1 = {rnd[2] | rnd[7], rnd[3],
            v0.va ^ {2'h0, rnd[15:12], 3'(rnd[1:0] == 2'h0), 5'h0}};
      vf = {rnd[8] & rnd[9],
            (rnd[10] ? v1.va : v0.va) ^ {rnd[11], 7'h0, rnd[5:0]}};
      st0 <= v0;
      st1 <= v1;
      ffl <= vf;
      @(negedge ref_clk_in);
      check(rep, er);
      check(reexec, cnt == 1);
      cnt = (er != 2'h0) ? 5 : (cnt > 0 ? cnt - 1 : 0);
      er[1] = v1.valid && ((v0.valid && v0.hit && v1.hit &&
        v0.va[7:5] == v1.va[7:5] && v0.va[11:8] != v1.va[11:8]) ||
        (vf.valid && vf.va[13:6] == v1.va[13:6]));
      er[0] = v0.valid && vf.valid && vf.va[13:6] == v0.va[13:6];
    end
    @(posedge ref_clk_in);
    st0 <= '0;
    st1 <= '0;
    ffl <= '0;
    repeat (8) @(posedge ref_clk_in);
    stalls = 0;
    errs = 0;
    q_out.delete();
    mpair({mk(4'h9, 16'h4530), mk(4'h9, 16'h1230)}, 6);
    mpair({mk(4'h4, 16'h6040), mk(4'h4, 16'h2040)}, 6);
    mpair({mk(4'hd, 16'h7050), mk(4'hd, 16'h3050)}, 6);
    mpair({mk(4'ha, 16'h1010), mk(4'ha, 16'h1000)}, 6);
    mpair({mk(4'h8, 16'h5560), mk(4'h8, 16'h5560)}, 6);
    mpair({21'h0, mk(4'h4, 16'h0870)}, 2);
    mpair({21'h0, mk(4'h8, 16'h1870)}, 6);
    mpair({21'h0, mk(4'h4, 16'h0990)}, 2);
    @(posedge ref_clk_in) mfill <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    mfill <= 1'b0;
    repeat (8) @(posedge ref_clk_in);
    check(stalls, 6);
    check(errs, 1);
    cmpq();
    drops = 0;
    for (n = 0; n < 8; n++) begin
      @(posedge ref_clk_in);
      rnd = lfsr(rnd);
      pf <= {1'b1, tbl[23 - 3 * n -: 3], rnd};
      if (tbl[23 - 3 * n] || tbl[22 - 3 * n -: 2] == 2'h3) begin
        if (q_exp.size() < 4) q_exp.push_back(rnd);
        else ed++;
      end
    end
    @(posedge ref_clk_in);
    pf <= '0;
    pfree <= 1'b1;
    repeat (12) @(posedge ref_clk_in);
    check(drops, ed);
    cmpq();
    test_done();
  end
endmodule // tb_top
`default_nettype wire
